//--- src/sdram_host_pkg.sv
// Constants and carrier types shared by the SDRAM controller host sequencer.
// Assumes a 40 MHz system clock and a 32-bit register interface to the controller.
package sdram_host_pkg;

    // Clock rate and the power-up pause
    localparam int CLOCK_MHZ = 40;
    localparam int PAUSE_US = 200;
    localparam int PAUSE_CYCLES = PAUSE_US * CLOCK_MHZ;
    localparam int PAUSE_W = 16;

    // Registers of the controller being driven (its own map)
    localparam logic [31:0] DEV_MR = 32'h0000_0000;
    localparam logic [31:0] DEV_TR = 32'h0000_0004;
    localparam logic [31:0] DEV_CR = 32'h0000_0008;
    localparam logic [31:0] DEV_LPR = 32'h0000_0010;
    localparam logic [31:0] DEV_ISR = 32'h0000_0020;
    localparam logic [31:0] DEV_MDR = 32'h0000_0024;
    localparam logic [31:0] DEV_CR_RESET = 32'h8523_72C0;
    localparam int ISR_REFRESH_ERR_BIT = 0;
    localparam int REFRESH_W = 12;
    localparam int LP_SELECT_W = 2;

    // Command-mode codes
    localparam logic [31:0] MODE_NORMAL = 32'h0000_0000;
    localparam logic [31:0] MODE_NOP = 32'h0000_0001;
    localparam logic [31:0] MODE_PRECHARGE_ALL = 32'h0000_0002;
    localparam logic [31:0] MODE_LOAD_MODE = 32'h0000_0003;
    localparam logic [31:0] MODE_AUTO_REFRESH = 32'h0000_0004;
    localparam logic [31:0] MODE_EXT_LOAD_MODE = 32'h0000_0005;
    localparam logic [2:0] AREF_LAST = 3'h7;
    localparam logic [1:0] LP_DEEP_POWER_DOWN = 2'h3;

    // Own register map, byte offsets on the AHB-Lite port
    localparam int OFS_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_LPR = 8'h0C;
    localparam logic [7:0] OFS_MDR = 8'h10;
    localparam logic [7:0] OFS_REFRESH = 8'h14;
    localparam logic [7:0] OFS_MRS_ADDR = 8'h18;
    localparam logic [7:0] OFS_EMRS_ADDR = 8'h1C;
    localparam logic [7:0] OFS_ACC_ADDR = 8'h20;
    localparam logic [7:0] OFS_ACC_DATA = 8'h24;
    localparam logic [7:0] OFS_RD_DATA = 8'h28;
    localparam logic [7:0] OFS_ISR_VAL = 8'h2C;

    // Control bits (write pulses, except the held CTRL_MOBILE bit) and status bits
    localparam int CTRL_INIT = 0;
    localparam int CTRL_MOBILE = 1;
    localparam int CTRL_ACC_WRITE = 2;
    localparam int CTRL_ACC_READ = 3;
    localparam int CTRL_ISR_READ = 4;
    localparam int CTRL_LPR_APPLY = 5;
    localparam int ST_BUSY = 0;
    localparam int ST_INIT_DONE = 1;
    localparam int ST_REFRESH_ERR = 2;
    localparam int ST_NEED_INIT = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_STEP_LSB = 8;

    // Sequence steps
    localparam logic [4:0] STEP_CFG = 5'h00;
    localparam logic [4:0] STEP_LPR = 5'h01;
    localparam logic [4:0] STEP_MDR = 5'h02;
    localparam logic [4:0] STEP_PAUSE = 5'h03;
    localparam logic [4:0] STEP_MODE_NOP = 5'h04;
    localparam logic [4:0] STEP_MEM_NOP = 5'h05;
    localparam logic [4:0] STEP_MODE_PALL = 5'h06;
    localparam logic [4:0] STEP_MEM_PALL = 5'h07;
    localparam logic [4:0] STEP_MODE_AREF = 5'h08;
    localparam logic [4:0] STEP_MEM_AREF = 5'h09;
    localparam logic [4:0] STEP_MODE_MRS = 5'h0A;
    localparam logic [4:0] STEP_MEM_MRS = 5'h0B;
    localparam logic [4:0] STEP_MODE_EMRS = 5'h0C;
    localparam logic [4:0] STEP_MEM_EMRS = 5'h0D;
    localparam logic [4:0] STEP_MODE_NORM = 5'h0E;
    localparam logic [4:0] STEP_MEM_NORM = 5'h0F;
    localparam logic [4:0] STEP_REFRESH = 5'h10;
    localparam logic [4:0] STEP_ACC_WR = 5'h11;
    localparam logic [4:0] STEP_ACC_RD = 5'h12;
    localparam logic [4:0] STEP_ISR = 5'h13;
    localparam logic [4:0] STEP_LPR_APPLY = 5'h14;

    // One access toward the controller: register space or SDRAM space
    typedef struct packed {
        logic mem_space;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dev_cmd_s;

    // One register write from the bus slave
    typedef struct packed {
        logic en;
        logic [OFS_W-1:0] addr;
        logic [31:0] data;
    } reg_wr_s;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_ISSUE = 3'b001,
        SEQ_WAIT_ACK = 3'b010,
        SEQ_WAIT_REL = 3'b011,
        SEQ_PAUSE = 3'b100
    } seq_state_e;

endpackage

//--- src/ahb_reg_slave.sv
// AHB-Lite slave for the host's own registers: zero-wait writes, one wait state on reads.
// Assumes a single slave whose hreadyout is the bus hready; response is always OKAY.
`timescale 1ns/1ps
module ahb_reg_slave
    import sdram_host_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // AHB-Lite
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // Register file side
    output reg_wr_s reg_wr_out,
    output logic [OFS_W-1:0] rd_addr_out,
    input wire logic [31:0] rd_data_in
);
    typedef struct packed {
        logic pend;
        logic pend_write;
        logic [OFS_W-1:0] addr;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } slave_s;

    slave_s cur;
    slave_s next_cur;
    logic take;

    // Only whole-word transfers exist, so hsize carries no information here
    assign take = hsel_in && htrans_in[1] && hready_in && (hsize_in == 3'h2 || hsize_in != 3'h2);
    assign reg_wr_out.en = cur.pend && cur.pend_write;
    assign reg_wr_out.addr = cur.addr;
    assign reg_wr_out.data = hwdata_in;
    assign rd_addr_out = cur.addr;
    assign hreadyout_out = cur.hreadyout;
    assign hresp_out = cur.hresp;
    assign hrdata_out = cur.hrdata;

    always_comb begin
        next_cur = cur;
        next_cur.hresp = 1'b0;
        if (cur.pend && !cur.pend_write) begin
            // Read data phase: sample the register after any earlier write has landed
            next_cur.hrdata = rd_data_in;
            next_cur.hreadyout = 1'b1;
            next_cur.pend = 1'b0;
        end else begin
            next_cur.pend = take;
            if (take) begin
                next_cur.pend_write = hwrite_in;
                next_cur.addr = haddr_in[OFS_W-1:0];
                next_cur.hreadyout = hwrite_in;
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cur <= '{pend: 1'b0, pend_write: 1'b0, addr: '0, hreadyout: 1'b1, hresp: 1'b0, hrdata: '0};
        end else begin
            cur <= next_cur;
        end
    end
endmodule

//--- src/sdram_host_seq.sv
// Host sequencer that drives an SDRAM controller through its register and memory ports.
// Assumes the controller answers each request with a level ack from another clock domain.
`timescale 1ns/1ps
module sdram_host_seq
    import sdram_host_pkg::*;
#(
    parameter int PAUSE_LEN = PAUSE_CYCLES
)(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // AHB-Lite register port
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // Controller access port
    output logic dev_req_out,
    output dev_cmd_s dev_cmd_out,
    input wire logic dev_ack_in,
    input wire logic [31:0] dev_rdata_in
);
    typedef struct packed {
        seq_state_e state;
        logic [4:0] step;
        logic [2:0] aref_cnt;
        logic [PAUSE_W-1:0] pause_cnt;
        logic mobile;
        logic init_done;
        logic need_init;
        logic refresh_err;
        logic refused;
        logic [31:0] cfg;
        logic [31:0] lpr;
        logic [31:0] mdr;
        logic [REFRESH_W-1:0] refresh;
        logic [31:0] mrs_addr;
        logic [31:0] emrs_addr;
        logic [31:0] acc_addr;
        logic [31:0] acc_data;
        logic [31:0] rd_data;
        logic [31:0] isr_val;
        logic ack_s1;
        logic ack_s2;
        logic [31:0] rdat_s1;
        logic [31:0] rdat_s2;
        logic dev_req;
        dev_cmd_s dev_cmd;
    } host_s;

    localparam logic [PAUSE_W-1:0] PAUSE_LAST = PAUSE_W'(PAUSE_LEN - 1);

    host_s cur;
    host_s next_cur;
    reg_wr_s reg_wr;
    logic [OFS_W-1:0] rd_addr;
    logic [31:0] rd_data;

    ahb_reg_slave bus_slave (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hsize_in(hsize_in),
        .hwdata_in(hwdata_in),
        .hready_in(hready_in),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out),
        .hrdata_out(hrdata_out),
        .reg_wr_out(reg_wr),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data)
    );

    assign dev_req_out = cur.dev_req;
    assign dev_cmd_out = cur.dev_cmd;

    // Access issued for a given step
    function automatic dev_cmd_s step_cmd(input host_s s);
        dev_cmd_s c;
        c = '{mem_space: 1'b0, write: 1'b1, addr: DEV_MR, wdata: MODE_NORMAL};
        case (s.step)
            STEP_CFG: begin
                c.addr = DEV_CR;
                c.wdata = s.cfg;
            end
            STEP_LPR, STEP_LPR_APPLY: begin
                c.addr = DEV_LPR;
                c.wdata = s.lpr;
            end
            STEP_MDR: begin
                c.addr = DEV_MDR;
                c.wdata = s.mdr;
            end
            STEP_MODE_NOP: c.wdata = MODE_NOP;
            STEP_MODE_PALL: c.wdata = MODE_PRECHARGE_ALL;
            STEP_MODE_AREF: c.wdata = MODE_AUTO_REFRESH;
            STEP_MODE_MRS: c.wdata = MODE_LOAD_MODE;
            STEP_MODE_EMRS: c.wdata = MODE_EXT_LOAD_MODE;
            STEP_MODE_NORM: c.wdata = MODE_NORMAL;
            STEP_MEM_NOP, STEP_MEM_PALL, STEP_MEM_AREF, STEP_MEM_NORM: begin
                c.mem_space = 1'b1;
                c.addr = s.acc_addr;
                c.wdata = s.acc_data;
            end
            STEP_MEM_MRS: begin
                c.mem_space = 1'b1;
                c.addr = s.mrs_addr;
            end
            STEP_MEM_EMRS: begin
                c.mem_space = 1'b1;
                c.addr = s.emrs_addr;
            end
            STEP_REFRESH: begin
                c.addr = DEV_TR;
                c.wdata = 32'(s.refresh);
            end
            STEP_ACC_WR: begin
                c.mem_space = 1'b1;
                c.addr = s.acc_addr;
                c.wdata = s.acc_data;
            end
            STEP_ACC_RD: begin
                c.mem_space = 1'b1;
                c.write = 1'b0;
                c.addr = s.acc_addr;
            end
            STEP_ISR: begin
                c.write = 1'b0;
                c.addr = DEV_ISR;
            end
            default: c.write = 1'b1;
        endcase
        return c;
    endfunction

    // Register read mux for the bus slave
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            OFS_CTRL: rd_data[CTRL_MOBILE] = cur.mobile;
            OFS_STATUS: begin
                rd_data[ST_BUSY] = (cur.state != SEQ_IDLE);
                rd_data[ST_INIT_DONE] = cur.init_done;
                rd_data[ST_REFRESH_ERR] = cur.refresh_err;
                rd_data[ST_NEED_INIT] = cur.need_init;
                rd_data[ST_REFUSED] = cur.refused;
                rd_data[ST_STEP_LSB +: 5] = cur.step;
            end
            OFS_CFG: rd_data = cur.cfg;
            OFS_LPR: rd_data = cur.lpr;
            OFS_MDR: rd_data = cur.mdr;
            OFS_REFRESH: rd_data = 32'(cur.refresh);
            OFS_MRS_ADDR: rd_data = cur.mrs_addr;
            OFS_EMRS_ADDR: rd_data = cur.emrs_addr;
            OFS_ACC_ADDR: rd_data = cur.acc_addr;
            OFS_ACC_DATA: rd_data = cur.acc_data;
            OFS_RD_DATA: rd_data = cur.rd_data;
            OFS_ISR_VAL: rd_data = cur.isr_val;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        logic idle;
        logic [4:0] start_step;
        logic start;
        idle = 1'b0;
        start_step = STEP_CFG;
        start = 1'b0;
        next_cur = cur;
        next_cur.ack_s1 = dev_ack_in;
        next_cur.ack_s2 = cur.ack_s1;
        next_cur.rdat_s1 = dev_rdata_in;
        next_cur.rdat_s2 = cur.rdat_s1;
        idle = (cur.state == SEQ_IDLE);

        // Register writes; setup values are held while a sequence runs
        if (reg_wr.en) begin
            case (reg_wr.addr)
                OFS_CTRL: begin
                    if (idle) begin
                        next_cur.mobile = reg_wr.data[CTRL_MOBILE];
                        if (reg_wr.data[CTRL_INIT]) begin
                            start = 1'b1;
                            start_step = STEP_CFG;
                        end else if (reg_wr.data[CTRL_ACC_WRITE] || reg_wr.data[CTRL_ACC_READ]) begin
                            if (cur.need_init || !cur.init_done) begin
                                next_cur.refused = 1'b1;
                            end else begin
                                start = 1'b1;
                                start_step = reg_wr.data[CTRL_ACC_WRITE] ? STEP_ACC_WR : STEP_ACC_RD;
                            end
                        end else if (reg_wr.data[CTRL_ISR_READ]) begin
                            start = 1'b1;
                            start_step = STEP_ISR;
                        end else if (reg_wr.data[CTRL_LPR_APPLY]) begin
                            start = 1'b1;
                            start_step = STEP_LPR_APPLY;
                        end
                    end
                end
                OFS_STATUS: begin
                    if (reg_wr.data[ST_REFRESH_ERR]) begin
                        next_cur.refresh_err = 1'b0;
                    end
                    if (reg_wr.data[ST_REFUSED]) begin
                        next_cur.refused = 1'b0;
                    end
                end
                OFS_CFG: if (idle) next_cur.cfg = reg_wr.data;
                OFS_LPR: if (idle) next_cur.lpr = reg_wr.data;
                OFS_MDR: if (idle) next_cur.mdr = reg_wr.data;
                OFS_REFRESH: if (idle) next_cur.refresh = reg_wr.data[REFRESH_W-1:0];
                OFS_MRS_ADDR: if (idle) next_cur.mrs_addr = reg_wr.data;
                OFS_EMRS_ADDR: if (idle) next_cur.emrs_addr = reg_wr.data;
                OFS_ACC_ADDR: if (idle) next_cur.acc_addr = reg_wr.data;
                OFS_ACC_DATA: if (idle) next_cur.acc_data = reg_wr.data;
                default: next_cur.refused = cur.refused;
            endcase
        end

        case (cur.state)
            SEQ_IDLE: begin
                if (start) begin
                    next_cur.step = start_step;
                    next_cur.aref_cnt = 3'h0;
                    next_cur.state = SEQ_ISSUE;
                    if (start_step == STEP_CFG) begin
                        next_cur.init_done = 1'b0;
                    end
                end
            end
            SEQ_ISSUE: begin
                next_cur.dev_cmd = step_cmd(cur);
                next_cur.dev_req = 1'b1;
                next_cur.state = SEQ_WAIT_ACK;
            end
            SEQ_WAIT_ACK: begin
                // stalled accesses simply hold the request
                if (cur.ack_s2) begin
                    next_cur.dev_req = 1'b0;
                    next_cur.state = SEQ_WAIT_REL;
                    if (cur.step == STEP_ACC_RD) begin
                        next_cur.rd_data = cur.rdat_s2;
                    end
                    if (cur.step == STEP_ISR) begin
                        next_cur.isr_val = cur.rdat_s2;
                        if (cur.rdat_s2[ISR_REFRESH_ERR_BIT]) begin
                            next_cur.refresh_err = 1'b1;
                        end
                    end
                end
            end
            SEQ_WAIT_REL: begin
                if (!cur.ack_s2) begin
                    next_cur.state = SEQ_ISSUE;
                    next_cur.step = cur.step + 5'h01;
                    case (cur.step)
                        STEP_CFG: next_cur.step = cur.mobile ? STEP_LPR : STEP_MDR;
                        STEP_MDR: begin
                            next_cur.pause_cnt = '0;
                            next_cur.state = SEQ_PAUSE;
                        end
                        STEP_MEM_AREF: begin
                            if (cur.aref_cnt != AREF_LAST) begin
                                next_cur.aref_cnt = cur.aref_cnt + 3'h1;
                                next_cur.step = STEP_MEM_AREF;
                            end
                        end
                        STEP_MEM_MRS: next_cur.step = cur.mobile ? STEP_MODE_EMRS : STEP_MODE_NORM;
                        STEP_REFRESH: begin
                            next_cur.init_done = 1'b1;
                            next_cur.need_init = 1'b0;
                            next_cur.state = SEQ_IDLE;
                        end
                        STEP_LPR_APPLY: begin
                            if (cur.lpr[LP_SELECT_W-1:0] == LP_DEEP_POWER_DOWN) begin
                                next_cur.need_init = 1'b1;
                            end
                            next_cur.state = SEQ_IDLE;
                        end
                        STEP_ACC_WR, STEP_ACC_RD, STEP_ISR: next_cur.state = SEQ_IDLE;
                        default: next_cur.state = SEQ_ISSUE;
                    endcase
                end
            end
            SEQ_PAUSE: begin
                next_cur.pause_cnt = cur.pause_cnt + 1'b1;
                if (cur.pause_cnt == PAUSE_LAST) begin
                    next_cur.step = STEP_MODE_NOP;
                    next_cur.state = SEQ_ISSUE;
                end
            end
            default: next_cur.state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cur <= '0;
            cur.cfg <= DEV_CR_RESET;
        end else begin
            cur <= next_cur;
        end
    end
endmodule

//--- verif/sdram_host_chk.sv
// Protocol checks on the host sequencer's bus port and controller link.
// Bound to sdram_host_seq; sees only its ports.
`timescale 1ns/1ps
module sdram_host_chk
    import sdram_host_pkg::*;
#(parameter int PAUSE_LEN = 20)(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Watched ports
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic dev_req_out,
    input wire dev_cmd_s dev_cmd_out,
    input wire logic dev_ack_in
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    logic req_d, cfg_seen, mem_seen;
    logic [2:0] last_mode;
    logic [15:0] gap;
    wire logic go = dev_req_out && !req_d;
    wire logic reg_go = go && !dev_cmd_out.mem_space;
    wire logic mem_go = go && dev_cmd_out.mem_space;
    // The pause is counted from the end of the memory-type write, not its start
    wire logic mdr_end = req_d && !dev_req_out && !dev_cmd_out.mem_space && dev_cmd_out.addr == DEV_MDR;
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            {req_d, cfg_seen, mem_seen, last_mode, gap} <= '0;
        end else begin
            req_d <= dev_req_out;
            cfg_seen <= cfg_seen || (reg_go && dev_cmd_out.addr == DEV_CR);
            mem_seen <= mem_seen || mem_go;
            if (reg_go && dev_cmd_out.addr == DEV_MR) begin
                last_mode <= dev_cmd_out.wdata[2:0];
            end
            // Saturating, so a long idle run cannot wrap back under the pause
            gap <= mdr_end ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
        end
    end
    a_write_zero_wait: assert property (hsel_in && htrans_in[1] && hwrite_in && hready_in |=> hreadyout_out)
        else $error("write data phase stalled");
    a_read_one_wait: assert property (hsel_in && htrans_in[1] && !hwrite_in && hready_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read data phase not one wait state");
    a_cmd_steady: assert property (dev_req_out && req_d |-> $stable(dev_cmd_out))
        else $error("command changed during request");
    a_req_waits: assert property (dev_req_out && !dev_ack_in |=> dev_req_out)
        else $error("request dropped before ack");
    a_req_releases: assert property (dev_req_out && dev_ack_in |-> ##[1:4] !dev_req_out)
        else $error("request held after ack");
    a_cfg_first: assert property (mem_go |-> cfg_seen)
        else $error("memory access before configuration");
    a_pause_kept: assert property (go && !$past(dev_cmd_out.mem_space) && $past(dev_cmd_out.addr) == DEV_MDR |-> gap >= PAUSE_LEN)
        else $error("power-up pause too short");
    a_resp_okay: assert property (!hresp_out)
        else $error("error response on the bus");
    a_nop_first: assert property (mem_go && !mem_seen |-> last_mode == 3'h1)
        else $error("first memory access not in nop mode");
endmodule

//--- verif/sdram_ctrl_model.sv
// Behavioural model of the SDRAM controller's register and memory ports.
// Runs on its own clock; answers each request with a level ack after lag_in cycles.
`timescale 1ns/1ps
module sdram_ctrl_model
    import sdram_host_pkg::*;
(
    // Own clock and knobs
    input wire logic link_in,
    input wire logic [3:0] lag_in,
    input wire logic err_in,
    // Request link
    input wire logic req_in,
    input wire dev_cmd_s cmd_in,
    output logic ack_out = 1'b0,
    output logic [31:0] rdata_out = 32'h0
);
    logic [31:0] mr = 0, tr = 0, cr = DEV_CR_RESET, lpr = 0, mdr = 0, isr = 0, mrs_at = 0, emrs_at = 0;
    logic [38:0] seq = 0;
    logic [3:0] cnt = 0;
    logic [31:0] mem [logic [31:0]];
    always @(posedge link_in) begin
        if (err_in) isr[0] = 1'b1;
        if (!req_in) begin
            ack_out = 1'b0;
            cnt = 0;
            // Idle data lines must not hold the last word
            rdata_out = ~rdata_out;
        end else if (!ack_out && cnt < lag_in) begin
            cnt++;
        end else if (!ack_out && cmd_in.mem_space) begin
            // single transfers only, never a fixed-length burst
            ack_out = 1'b1;
            if (cmd_in.write) seq = {seq[35:0], mr[2:0]};
            if (cmd_in.write && mr == MODE_NORMAL) mem[cmd_in.addr] = cmd_in.wdata;
            if (mr == MODE_LOAD_MODE) mrs_at = cmd_in.addr;
            if (mr == MODE_EXT_LOAD_MODE) emrs_at = cmd_in.addr;
            rdata_out = mem.exists(cmd_in.addr) ? mem[cmd_in.addr] : 32'hDEAD_0BAD;
        end else if (!ack_out) begin
            ack_out = 1'b1;
            if (cmd_in.write) case (cmd_in.addr)
                DEV_MR: mr = cmd_in.wdata;
                // refresh count kept to 12 bits
                DEV_TR: tr = {20'h0, cmd_in.wdata[11:0]};
                DEV_CR: cr = cmd_in.wdata;
                // low-power select kept for the power state
                DEV_LPR: lpr = cmd_in.wdata;
                DEV_MDR: mdr = cmd_in.wdata;
                default: ;
            endcase
            else if (cmd_in.addr == DEV_ISR) begin
                rdata_out = isr;
                isr = 32'h0;
            end
        end
    end
endmodule

//--- verif/testbench.sv
// Register-level test of the SDRAM host sequencer against a controller model.
// AHB-Lite master tasks; link model on its own unrelated clock.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import sdram_host_pkg::*;
    logic clock_in = 0, link = 0, reset_in = 1, hsel = 0, hwrite = 0, err = 0, hready, req, ack;
    logic [1:0] htrans = 0;
    logic [3:0] lag = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, mrd;
    dev_cmd_s cmd;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    sdram_host_seq #(.PAUSE_LEN(20)) dut (.clock_in(clock_in), .reset_in(reset_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hreadyout_out(hready), .hresp_out(), .hrdata_out(hrdata), .dev_req_out(req),
        .dev_cmd_out(cmd), .dev_ack_in(ack), .dev_rdata_in(mrd));
    sdram_ctrl_model mdl (.link_in(link), .lag_in(lag), .err_in(err), .req_in(req), .cmd_in(cmd),
        .ack_out(ack), .rdata_out(mrd));
    initial forever #12.5 clock_in = ~clock_in;
    initial begin
        #37;
        forever #100 link = ~link;
    end
    task summarize;
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(posedge clock_in); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge clock_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task run(input logic [31:0] c);
        xfer(1, OFS_CTRL, c);
        do xfer(0, OFS_STATUS, 0); while (rd[ST_BUSY] !== 1'b0);
    endtask
    initial begin
        repeat (4) @(posedge clock_in);
        reset_in <= 1'b0;
        xfer(0, OFS_CFG, 0); `CHK(rd, DEV_CR_RESET)
        xfer(0, 8'h40, 0); `CHK(rd, 32'h0)
        xfer(1, OFS_ACC_ADDR, 32'h100);
        run(32'h4); `CHK(rd[ST_REFUSED], 1'b1)
        `CHK(mdl.seq, 39'h0)
        xfer(1, OFS_STATUS, 32'h10);
        xfer(1, OFS_CFG, 32'h1234_5679);
        xfer(1, OFS_LPR, 32'h0000_0020);
        xfer(1, OFS_MDR, 32'h1);
        xfer(1, OFS_REFRESH, 32'h0000_1ABC);
        xfer(1, OFS_MRS_ADDR, 32'h2000_0000);
        xfer(1, OFS_EMRS_ADDR, 32'h2040_0000);
        xfer(0, OFS_REFRESH, 0); `CHK(rd, 32'h0ABC)
        run(32'h3); `CHK(rd[ST_INIT_DONE], 1'b1)
        `CHK({mdl.cr, mdl.lpr, mdl.mdr}, {32'h1234_5679, 32'h20, 32'h1})
        `CHK(mdl.seq, {3'h1, 3'h2, {8{3'h4}}, 3'h3, 3'h5, 3'h0})
        `CHK({mdl.mrs_at, mdl.emrs_at}, {32'h2000_0000, 32'h2040_0000})
        `CHK({mdl.mr, mdl.tr}, {32'h0, 32'h0ABC})
        lag <= 4'h7;
        xfer(1, OFS_ACC_DATA, 32'h5A5A_A5A5);
        run(32'h4);
        run(32'h8);
        xfer(0, OFS_RD_DATA, 0); `CHK(rd, 32'h5A5A_A5A5)
        @(posedge link) err <= 1'b1;
        @(posedge link) err <= 1'b0;
        run(32'h10); `CHK(rd[ST_REFRESH_ERR], 1'b1)
        xfer(0, OFS_ISR_VAL, 0); `CHK(rd[0], 1'b1)
        `CHK(mdl.isr, 32'h0)
        xfer(1, OFS_STATUS, 32'h4);
        xfer(0, OFS_STATUS, 0); `CHK(rd[ST_REFRESH_ERR], 1'b0)
        xfer(1, OFS_LPR, 32'h3);
        run(32'h20); `CHK(rd[ST_NEED_INIT], 1'b1)
        `CHK(mdl.lpr[1:0], LP_DEEP_POWER_DOWN)
        run(32'h4); `CHK(rd[ST_REFUSED], 1'b1)
        run(32'h1); `CHK(rd[ST_NEED_INIT], 1'b0)
        `CHK(mdl.seq, {3'h0, 3'h1, 3'h2, {8{3'h4}}, 3'h3, 3'h0})
        summarize();
    end
endmodule
bind sdram_host_seq sdram_host_chk #(.PAUSE_LEN(PAUSE_LEN)) chk (.clock_in(clock_in), .reset_in(reset_in),
    .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .dev_req_out(dev_req_out),
    .dev_cmd_out(dev_cmd_out), .dev_ack_in(dev_ack_in));
